/* core/io_port_pkg.sv */
// Purpose: shared constants and carrier types for the shared io port
// Assumes: one port of up to 16 pins, change notify on up to 24 inputs
// Notes: reset values are per-pin masks, applied by the port logic
package io_port_pkg;
  localparam int unsigned PORT_WIDTH = 16;
  localparam int unsigned CN_WIDTH = 24;
  localparam int unsigned CN_HALF = 16;
  localparam int unsigned SYNC_STAGES = 3;
  // all pins come out of reset as inputs
  localparam logic [PORT_WIDTH-1:0] DIR_RESET = 16'hffff;
  localparam logic [PORT_WIDTH-1:0] LATCH_RESET = 16'h0000;
  localparam logic [PORT_WIDTH-1:0] ODC_RESET = 16'h0000;
  // config bit clear means analog, so reset is all zero
  localparam logic [PORT_WIDTH-1:0] ANALOG_CFG_RESET = 16'h0000;
  localparam logic [CN_HALF-1:0] CN_REG_RESET = 16'h0000;

  // software write request to one of the port registers
  typedef enum logic [2:0] {
    WR_NONE = 3'b000,
    WR_DIR = 3'b001,
    WR_LATCH = 3'b010,
    WR_PIN_LEVEL = 3'b011,
    WR_ODC = 3'b100,
    WR_CN_EN_A = 3'b101,
    WR_CN_EN_B = 3'b110,
    WR_PULLUP = 3'b111
  } wr_sel_type;

  // peripheral claim on a pin group
  typedef struct packed {
    logic [PORT_WIDTH-1:0] enable;
    logic [PORT_WIDTH-1:0] drive;
    logic [PORT_WIDTH-1:0] out_data;
    logic [PORT_WIDTH-1:0] out_en;
  } periph_claim_type;

  // pin pad drive for the port
  typedef struct packed {
    logic [PORT_WIDTH-1:0] out;
    logic [PORT_WIDTH-1:0] oe;
  } pad_drive_type;
endpackage

/* core/shared_io_port.sv */
// Purpose: shared io port with pin muxing, analog override, change notify
// Assumes: pins are sampled asynchronously; registers are plain ports
// Notes: one pullup write loads both halves; block b takes its high byte
// How it works
// R1 - peripheral that claims and drives a pin owns its output data and enable
// R2 - actively driving peripheral disables port driver; pin still readable
// R3 - enabled but idle peripheral lets port drive from direction and latch
// R4 - port output never loops into a sharing peripheral's input
// R5 - direction one is input with driver off; zero drives latch
// R6 - every reset sets all direction bits, making pins inputs
// R7 - latch reads return the latch; latch writes touch only it
// R8 - pin level reads return pins; writes to it update the latch
// R9 - unimplemented bits read zero in latch, direction and level
// R10 - input-only shared pin is plain port pin without competing output
// R11 - open-drain bit makes pin drive only low
// R12 - cleared analog config bit makes pin analog; reset is analog
// R13 - pin is analog if either converter's config bit is clear
// R14 - analog pins read zero through pin level
// R15 - software sets direction for analog inputs or output is converted
// R16 - software waits one cycle between port write and read
// R17 - change of a selected input raises request; 24 inputs
// R18 - change detection works while the system clock is stopped
// R19 - per-pin change enable across two registers gates the request
// R20 - per-pin pullup enable across two registers switches weak pullup; here one write loads both, inputs 16-23 taking bits 8-15
// R21 - software clears pullups on digital output pins
// R22 - enabled inputs differing from recorded level set a shared flag
// R23 - pin levels pass a synchroniser on the instruction clock
`timescale 1ns/100ps
`default_nettype none
module shared_io_port #(
  parameter logic [io_port_pkg::PORT_WIDTH-1:0] IMPL_MASK = 16'hffff,
  parameter logic [io_port_pkg::PORT_WIDTH-1:0] ANALOG_MASK = 16'h00ff,
  parameter logic [io_port_pkg::CN_WIDTH-1:0] CN_IMPL_MASK = 24'hffffff
) (
  // clock, enable, reset
  input wire logic clk_sys_in,
  input wire logic clk_en_in,
  input wire logic rst_b_in,
  // software register access
  input wire io_port_pkg::wr_sel_type wr_sel_in,
  input wire logic [io_port_pkg::PORT_WIDTH-1:0] wr_data_in,
  input wire logic [io_port_pkg::PORT_WIDTH-1:0] analog_cfg_a_in,
  input wire logic [io_port_pkg::PORT_WIDTH-1:0] analog_cfg_b_in,
  input wire logic cn_clear_in,
  output logic [io_port_pkg::PORT_WIDTH-1:0] pin_direction_out,
  output logic [io_port_pkg::PORT_WIDTH-1:0] output_latch_out,
  output logic [io_port_pkg::PORT_WIDTH-1:0] pin_level_out,
  output logic [io_port_pkg::PORT_WIDTH-1:0] open_drain_select_out,
  // peripherals sharing the pins
  input wire io_port_pkg::periph_claim_type periph_in,
  output logic [io_port_pkg::PORT_WIDTH-1:0] periph_rx_out,
  // pins
  input wire logic [io_port_pkg::PORT_WIDTH-1:0] pad_in,
  output logic [io_port_pkg::PORT_WIDTH-1:0] pad_out,
  output logic [io_port_pkg::PORT_WIDTH-1:0] pad_oe_out,
  output logic [io_port_pkg::PORT_WIDTH-1:0] analog_sel_out,
  // change notify
  input wire logic [io_port_pkg::CN_WIDTH-1:0] cn_pin_in,
  input wire logic sleep_in,
  output logic [io_port_pkg::CN_WIDTH-1:0] pullup_en_out,
  output logic cn_irq_out
);
  import io_port_pkg::*;

  localparam int unsigned PW = PORT_WIDTH;
  localparam int unsigned CW = CN_WIDTH;

  // refuse widths that the fixed two-half register split cannot serve
  if (PW != 16 || CW > 2 * CN_HALF || CW <= CN_HALF ||
      SYNC_STAGES != 3) begin : gen_bad_width
    $error("shared_io_port: unsupported width parameters");
  end

  logic [1:0] rst_sync_reg;
  logic rst_b;
  logic [PW-1:0] dir_reg, latch_reg, odc_reg;
  logic [CN_HALF-1:0] cn_en_a_reg, cn_en_b_reg, pu_a_reg, pu_b_reg;
  logic [PW-1:0] pin_s1_reg, pin_s2_reg, pin_s3_reg, pin_stable_reg;
  logic [CW-1:0] cn_s1_reg, cn_s2_reg, cn_s3_reg, cn_stable_reg;
  logic [CW-1:0] cn_prev_reg;
  logic [CW-1:0] cn_enables;
  logic [PW-1:0] analog_now, port_oe, port_out, port_drv;
  logic [PW-1:0] pad_oe;
  logic [PW-1:0] pad_out_next, pad_oe_next;
  logic cn_flag_reg, cn_wake_reg, cn_hit;

  // reset release through two flops, assert stays asynchronous
  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rst_sync_reg <= 2'b00;
    end else begin
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
  end
  assign rst_b = rst_sync_reg[1];

  // software-visible control registers
  always_ff @(posedge clk_sys_in or negedge rst_b) begin
    if (!rst_b) begin
      dir_reg <= DIR_RESET; // R6
      latch_reg <= LATCH_RESET;
      odc_reg <= ODC_RESET;
    end else if (clk_en_in) begin
      case (wr_sel_in)
        WR_DIR: dir_reg <= wr_data_in & IMPL_MASK; // R9
        WR_LATCH: latch_reg <= wr_data_in & IMPL_MASK; // R7
        WR_PIN_LEVEL: latch_reg <= wr_data_in & IMPL_MASK; // R8
        WR_ODC: odc_reg <= wr_data_in & IMPL_MASK; // R11
        default: ;
      endcase
    end
  end

  // change enable and pullup halves; b halves hold cn inputs 16 and up
  always_ff @(posedge clk_sys_in or negedge rst_b) begin
    if (!rst_b) begin
      cn_en_a_reg <= CN_REG_RESET;
      cn_en_b_reg <= CN_REG_RESET;
      pu_a_reg <= CN_REG_RESET;
      pu_b_reg <= CN_REG_RESET;
    end else if (clk_en_in) begin
      case (wr_sel_in)
        WR_CN_EN_A: cn_en_a_reg <= wr_data_in; // R19
        WR_CN_EN_B: cn_en_b_reg <= wr_data_in; // R19
        WR_PULLUP: begin
          // one strobe loads both halves: all 16 bits to a, the high byte to b
          pu_a_reg <= wr_data_in; // R20
          pu_b_reg <= {8'h00, wr_data_in[15:8]}; // R20
        end
        default: ;
      endcase
    end
  end

  // three-flop pin synchroniser; a change counts when stages 2 and 3 agree
  always_ff @(posedge clk_sys_in or negedge rst_b) begin
    if (!rst_b) begin
      pin_s1_reg <= '0;
      pin_s2_reg <= '0;
      pin_s3_reg <= '0;
      pin_stable_reg <= '0;
    end else if (clk_en_in) begin
      pin_s1_reg <= pad_in; // R23
      pin_s2_reg <= pin_s1_reg;
      pin_s3_reg <= pin_s2_reg;
      for (int i = 0; i < PW; i++) begin
        if (pin_s2_reg[i] == pin_s3_reg[i]) begin
          pin_stable_reg[i] <= pin_s3_reg[i];
        end
      end
    end
  end

  // either converter's clear config bit makes an analog-capable pin analog
  assign analog_now = ANALOG_MASK & ~(analog_cfg_a_in & analog_cfg_b_in); // R12 R13

  // output mux: a claiming, driving peripheral owns data and enable
  always_comb begin
    port_oe = ~dir_reg & IMPL_MASK; // R5
    port_out = latch_reg;
    // pins the port really drives, a driving sharer having taken the rest
    port_drv = port_oe & ~(periph_in.enable & periph_in.drive); // R4
    pad_out_next = '0;
    pad_oe_next = '0;
    for (int i = 0; i < PW; i++) begin
      if (periph_in.enable[i] && periph_in.drive[i]) begin
        pad_out_next[i] = periph_in.out_data[i]; // R1 R2
        pad_oe_next[i] = periph_in.out_en[i]; // R1 R2
      end else begin
        // idle or input-only sharer leaves the pin to the port
        pad_out_next[i] = port_out[i] & ~odc_reg[i]; // R3 R10 R11
        pad_oe_next[i] = port_oe[i] & (~odc_reg[i] | ~port_out[i]); // R11
      end
    end
  end

  // outputs all registered so pads never see mux glitches
  always_ff @(posedge clk_sys_in or negedge rst_b) begin
    if (!rst_b) begin
      pad_out <= '0;
      pad_oe <= '0;
      analog_sel_out <= ANALOG_MASK; // R12
      pin_level_out <= '0;
      periph_rx_out <= '0;
      pin_direction_out <= DIR_RESET & IMPL_MASK; // R6
      output_latch_out <= '0;
      open_drain_select_out <= '0;
      pullup_en_out <= '0;
    end else if (clk_en_in) begin
      pad_out <= pad_out_next;
      pad_oe <= pad_oe_next;
      analog_sel_out <= analog_now;
      pin_level_out <= pin_stable_reg & ~analog_now & IMPL_MASK; // R8 R14 R9
      // while the port drives a pin, the sharer sees low, not our output
      periph_rx_out <= pin_stable_reg & ~port_drv; // R4
      pin_direction_out <= dir_reg & IMPL_MASK; // R9
      output_latch_out <= latch_reg & IMPL_MASK; // R7 R9
      open_drain_select_out <= odc_reg;
      pullup_en_out <= {pu_b_reg[CW-CN_HALF-1:0], pu_a_reg} & CN_IMPL_MASK; // R20
    end
  end
  assign pad_oe_out = pad_oe;

  assign cn_enables = {cn_en_b_reg[CW-CN_HALF-1:0], cn_en_a_reg} & CN_IMPL_MASK;

  // change input stages run with the enable low, so sleep still sees pins
  always_ff @(posedge clk_sys_in or negedge rst_b) begin
    if (!rst_b) begin
      cn_s1_reg <= '0;
      cn_s2_reg <= '0;
      cn_s3_reg <= '0;
    end else begin
      cn_s1_reg <= cn_pin_in;
      cn_s2_reg <= cn_s1_reg;
      cn_s3_reg <= cn_s2_reg; // R18
    end
  end

  // settled change levels and the recorded level freeze with the enable
  always_ff @(posedge clk_sys_in or negedge rst_b) begin
    if (!rst_b) begin
      cn_stable_reg <= '0;
      cn_prev_reg <= '0;
    end else if (clk_en_in) begin
      for (int i = 0; i < CW; i++) begin
        if (cn_s2_reg[i] == cn_s3_reg[i]) begin
          cn_stable_reg[i] <= cn_s3_reg[i];
        end
      end
      cn_prev_reg <= cn_stable_reg; // R22
    end
  end

  assign cn_hit = |((cn_stable_reg ^ cn_prev_reg) & cn_enables); // R17 R22

  // shared flag: a new change wins over a clear in the same cycle
  always_ff @(posedge clk_sys_in or negedge rst_b) begin
    if (!rst_b) begin
      cn_flag_reg <= 1'b0;
    end else if (clk_en_in) begin
      if (cn_hit || cn_wake_reg) begin
        cn_flag_reg <= 1'b1; // R22
      end else if (cn_clear_in) begin
        cn_flag_reg <= 1'b0;
      end
    end
  end

  // sleep path: settled stages against the recorded level raise the
  // request at once; the flag catches it on the first enabled edge
  always_ff @(posedge clk_sys_in or negedge rst_b) begin
    if (!rst_b) begin
      cn_wake_reg <= 1'b0;
      cn_irq_out <= 1'b0;
    end else begin
      cn_wake_reg <= sleep_in & |((cn_s2_reg ~^ cn_s3_reg) &
        (cn_s3_reg ^ cn_prev_reg) & cn_enables); // R18
      cn_irq_out <= cn_flag_reg | cn_wake_reg; // R17 R18
    end
  end

  // assertions
  dir_reset_a: assert property (@(posedge clk_sys_in)
    $rose(rst_b) |-> pin_direction_out == IMPL_MASK ##1
    pin_direction_out == IMPL_MASK) else $error("pins not inputs after reset"); // R6
  pin_write_a: assert property (@(posedge clk_sys_in) disable iff (!rst_b)
    clk_en_in && wr_sel_in == WR_PIN_LEVEL |=> latch_reg ==
    ($past(wr_data_in) & IMPL_MASK)) else $error("pin write missed latch"); // R8
  input_off_a: assert property (@(posedge clk_sys_in) disable iff (!rst_b)
    clk_en_in && dir_reg[0] && !(periph_in.enable[0] && periph_in.drive[0])
    |=> !pad_oe[0]) else $error("input pin driven"); // R5
  periph_own_a: assert property (@(posedge clk_sys_in) disable iff (!rst_b)
    clk_en_in && periph_in.enable[1] && periph_in.drive[1] |=>
    pad_out[1] == $past(periph_in.out_data[1])) else $error("port kept pin"); // R1
  open_drain_a: assert property (@(posedge clk_sys_in) disable iff (!rst_b)
    clk_en_in && odc_reg[2] && !(periph_in.enable[2] && periph_in.drive[2])
    |=> !(pad_oe[2] && pad_out[2])) else $error("open drain drove high"); // R11
  analog_zero_a: assert property (@(posedge clk_sys_in) disable iff (!rst_b)
    clk_en_in && analog_now[3] |=> !pin_level_out[3])
    else $error("analog pin read high"); // R14
  cn_flag_a: assert property (@(posedge clk_sys_in) disable iff (!rst_b)
    clk_en_in && cn_hit |=> cn_flag_reg ##1 cn_irq_out)
    else $error("change not flagged"); // R22
  unimpl_zero_a: assert property (@(posedge clk_sys_in) disable iff (!rst_b)
    (output_latch_out & ~IMPL_MASK) == '0 && (pin_level_out & ~IMPL_MASK) == '0
    && (pin_direction_out & ~IMPL_MASK) == '0)
    else $error("unimplemented bit read one"); // R9
  loop_block_a: assert property (@(posedge clk_sys_in) disable iff (!rst_b)
    clk_en_in && port_drv[4] |=> !periph_rx_out[4])
    else $error("port looped into peripheral"); // R4
endmodule
`default_nettype wire

/* testbench/pin_model.sv */
// Purpose: pin level model for the pads of the shared io port
// Assumes: weak pull-ups on pins 0-15 follow the low pullup enables
// Notes: floating pins toggle each clock so a stale level never passes
`timescale 1ns/100ps
`default_nettype none
module pin_model (
  // clock
  input wire logic clk_sys_in,
  // port drive, pull-ups and outside drivers
  input wire logic [15:0] pad_out_in,
  input wire logic [15:0] pad_oe_in,
  input wire logic [15:0] pullup_in,
  input wire logic [15:0] ext_data_in,
  input wire logic [15:0] ext_en_in,
  // resolved pin levels
  output logic [15:0] pad_level_out
);
  logic [15:0] float_reg = 16'h5555;
  // undriven pins wander, since the simulator would settle x by whim
  always_ff @(posedge clk_sys_in) begin
    float_reg <= ~float_reg;
  end
  // port drive first, then outside drive, then the weak pull-up
  always_comb begin
    pad_level_out = (pad_oe_in & pad_out_in)
      | (~pad_oe_in & ext_en_in & ext_data_in)
      | (~pad_oe_in & ~ext_en_in & (pullup_in | float_reg));
  end
endmodule
`default_nettype wire

/* testbench/tb_shared_io_port.sv */
// Purpose: self-checking bench for the shared io port
// Assumes: pin 15 left unimplemented to exercise the masking
// Notes: readback is checked a few cycles after each write
`timescale 1ns/100ps
`default_nettype none
module tb_shared_io_port;
  import io_port_pkg::*;
  localparam logic [15:0] IMPL = 16'h7fff;
  logic clk_sys = 1'b0;
  logic clk_en = 1'b1;
  logic rst_b = 1'b0;
  logic cn_clear = 1'b0;
  logic sleep = 1'b0;
  wr_sel_type wr_sel = WR_NONE;
  logic [15:0] wr_data = 16'h0000;
  logic [15:0] cfg_a = 16'h0000;
  logic [15:0] cfg_b = 16'h0000;
  logic [15:0] ext_data = 16'h0000;
  logic [15:0] ext_en = 16'h0000;
  logic [23:0] cn_pin = 24'h000000;
  periph_claim_type periph = '0;
  logic [15:0] dir, lat, lvl, odc, rx, pad_in, pout, poe, asel;
  logic [23:0] pu;
  logic irq;
  int n_tests = 0;
  int n_mismatch = 0;
  // free-running 100 MHz clock
  initial begin
    forever #5 clk_sys = ~clk_sys;
  end
  shared_io_port #(.IMPL_MASK(IMPL)) u_shared_io_port (
    .clk_sys_in(clk_sys), .clk_en_in(clk_en), .rst_b_in(rst_b),
    .wr_sel_in(wr_sel), .wr_data_in(wr_data), .analog_cfg_a_in(cfg_a),
    .analog_cfg_b_in(cfg_b), .cn_clear_in(cn_clear),
    .pin_direction_out(dir), .output_latch_out(lat),
    .pin_level_out(lvl), .open_drain_select_out(odc),
    .periph_in(periph), .periph_rx_out(rx), .pad_in(pad_in),
    .pad_out(pout), .pad_oe_out(poe), .analog_sel_out(asel),
    .cn_pin_in(cn_pin), .sleep_in(sleep), .pullup_en_out(pu),
    .cn_irq_out(irq));
  pin_model u_pin_model (
    .clk_sys_in(clk_sys), .pad_out_in(pout), .pad_oe_in(poe),
    .pullup_in(pu[15:0]), .ext_data_in(ext_data), .ext_en_in(ext_en),
    .pad_level_out(pad_in));
  // wait n edges, then let their updates settle
  task automatic step(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  // one enabled write cycle, then time for readback to land
  task automatic wr(input wr_sel_type s, input logic [15:0] d);
    @(posedge clk_sys);
    wr_sel <= s;
    wr_data <= d;
    @(posedge clk_sys);
    wr_sel <= WR_NONE;
    step(3);
  endtask
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic end_of_test;
    $display("tests=%0d mismatches=%0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // bounded wait for the change request
  task automatic wait_irq;
    int k;
    k = 0;
    while (irq !== 1'b1 && k < 50) begin
      step(1);
      k++;
    end
    n_tests++;
    if (k == 50) begin
      n_mismatch++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, irq, 1'b1);
      end_of_test();
    end
  endtask
  // main sequence
  initial begin
    step(2);
    rst_b <= 1'b1;
    step(6);
    chk(dir, IMPL);
    chk(asel, 16'h00ff);
    wr(WR_DIR, 16'h0000);
    wr(WR_LATCH, 16'ha5c3);
    chk(lat, 16'h25c3);
    chk(poe & IMPL, IMPL);
    chk(pout & IMPL, 16'h25c3);
    wr(WR_PIN_LEVEL, 16'h3c3c);
    chk(lat, 16'h3c3c);
    wr(WR_ODC, 16'h00ff);
    chk(odc, 16'h00ff);
    chk(poe & IMPL, 16'h7fc3);
    chk(pout & poe, 16'h3c00);
    wr(WR_ODC, 16'h0000);
    wr(WR_LATCH, 16'hffff);
    // pins 0-1 claimed and driven, pins 2-3 claimed but idle
    periph <= '{enable: 16'h000f, drive: 16'h0003,
      out_data: 16'h0001, out_en: 16'h0003};
    step(8);
    chk(pout[3:0], 4'hd);
    chk(poe[3:0], 4'hf);
    chk(rx[3:0], 4'h1);
    periph <= '0;
    wr(WR_DIR, 16'hffff);
    ext_en <= 16'hffff;
    ext_data <= 16'ha5a5;
    step(8);
    chk(poe, 16'h0000);
    chk(lvl, 16'h2500);
    cfg_a <= 16'hffff;
    cfg_b <= 16'hffff;
    step(8);
    chk(lvl, 16'h25a5);
    cfg_b <= 16'hfffe;
    step(8);
    chk(lvl, 16'h25a4);
    chk(asel, 16'h0001);
    wr(WR_PULLUP, 16'h8001);
    chk(pu, 24'h808001);
    wr(WR_CN_EN_A, 16'h0001);
    cn_pin <= 24'h000002;
    step(20);
    chk(irq, 1'b0);
    cn_pin <= 24'h000000;
    step(20);
    cn_pin <= 24'h000001;
    wait_irq();
    cn_clear <= 1'b1;
    step(1);
    cn_clear <= 1'b0;
    step(4);
    chk(irq, 1'b0);
    // the b half enables change inputs 16 and up
    wr(WR_CN_EN_B, 16'h0080);
    cn_pin <= 24'h800001;
    wait_irq();
    cn_clear <= 1'b1;
    step(1);
    cn_clear <= 1'b0;
    step(4);
    chk(irq, 1'b0);
    // clocks stopped: detection must still raise the request
    sleep <= 1'b1;
    clk_en <= 1'b0;
    step(2);
    chk(irq, 1'b0);
    cn_pin <= 24'h000000;
    wait_irq();
    end_of_test();
  end
endmodule
`default_nettype wire
